// *** common/cache_port_pkg.sv ***
// Constants and types for the off-chip cache port timing block
package cache_port_pkg;
	// ==========================================================
	// Field widths
	localparam int DATA_PAT_W = 32;
	localparam int TAG_PAT_W = 24;
	localparam int LW_CACHE_W = 3;
	localparam int LW_CORE_W = 2;
	localparam int RATIO_W = 3;
	// ==========================================================
	// Timing
	localparam int LINE_DEPTH = 9;
	localparam int TAP_W = 4;
	localparam int FILL_BEATS = 4;
	localparam int BEAT_W = 2;
	localparam logic [TAP_W-1:0] PHASES_PER_CORE = 4'h2;
	// Phase delay per clock delay encoding
	localparam logic [TAP_W-1:0] CLK_DELAY_ENC0 = 4'h0;
	localparam logic [TAP_W-1:0] CLK_DELAY_ENC1 = 4'h0;
	localparam logic [TAP_W-1:0] CLK_DELAY_ENC2 = 4'h1;
	localparam logic [TAP_W-1:0] CLK_DELAY_ENC3 = 4'h2;
	// ==========================================================
	// Reset values
	localparam logic [DATA_PAT_W-1:0] DATA_PAT_RST = 32'h0000_0000;
	localparam logic [TAG_PAT_W-1:0] TAG_PAT_RST = 24'h00_0000;
	// ==========================================================
	// Transaction sequencer
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ALIGN = 3'b001,
		ST_WDELAY = 3'b010,
		ST_WDATA = 3'b011,
		ST_RWAIT = 3'b100
	} port_state_t;
endpackage

// *** logic/cache_port_timing.sv ***
// Off-chip cache port timing logic driven by static configuration fields
`timescale 1ns/1ps
module cache_port_timing import cache_port_pkg::*; #(
	parameter int IDX_W = 20,
	parameter int DATA_W = 16,
	parameter int TAG_W = 12
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic speculative_read_en,
	input wire logic probe_check_en,
	input wire logic store_cond_export_en,
	input wire logic probe_stall_cfg,
	input wire logic [RATIO_W-1:0] cache_clock_ratio,
	input wire logic [DATA_PAT_W-1:0] data_latency_pattern,
	input wire logic [TAG_PAT_W-1:0] tag_latency_pattern,
	input wire logic [LW_CACHE_W-1:0] late_write_cache_clocks,
	input wire logic [LW_CORE_W-1:0] late_write_core_cycles,
	input wire logic burst_transfer_en,
	input wire logic frame_on_a_phase,
	input wire logic [1:0] cache_clock_phase_delay,
	input wire logic fwd_clock_rise_en,
	input wire logic fwd_clock_fall_en,
	input wire logic tag_update_fall_en,
	input wire logic tag_update_rise_en,
	input wire logic clock_forwarding_en,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_probe,
	input wire logic req_spec_read,
	input wire logic req_stc,
	input wire logic [IDX_W-1:0] req_index,
	input wire logic [TAG_W-1:0] req_tag,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic [IDX_W-1:0] cache_index,
	output logic cache_index_valid,
	output logic [DATA_W-1:0] cache_data_out,
	output logic cache_data_oe,
	input wire logic [DATA_W-1:0] cache_data_in,
	input wire logic cache_data_par_in,
	output logic [TAG_W-1:0] cache_tag_out,
	input wire logic [TAG_W-1:0] cache_tag_in,
	input wire logic cache_tag_par_in,
	output logic fwd_clock,
	output logic [DATA_W-1:0] rsp_data,
	output logic rsp_data_valid,
	output logic [TAG_W-1:0] rsp_tag,
	output logic rsp_tag_valid,
	output logic probe_error,
	output logic sys_spec_read,
	output logic sys_stc_cmd
);
	// ==========================================================
	// Declarations
	port_state_t state_q;
	logic accept;
	logic phase_a_q;
	logic [RATIO_W-1:0] half_cnt_q;
	logic cclk_raw_q;
	logic [LINE_DEPTH-1:0] cclk_line_q;
	logic [TAP_W-1:0] core_tap;
	logic [TAP_W-1:0] full_tap;
	logic [TAP_W-1:0] phase_dly;
	logic data_clk_q;
	logic fwd_src_q;
	logic data_rise;
	logic fwd_rise;
	logic fwd_fall;
	logic raw_rise;
	logic start_ok;
	logic [DATA_W-1:0] din_s1_q, din_s2_q;
	logic [TAG_W-1:0] tin_s1_q, tin_s2_q;
	logic dpar_s1_q, dpar_s2_q, tpar_s1_q, tpar_s2_q;
	logic wr_q, probe_q;
	logic [IDX_W-1:0] idx_q;
	logic [TAG_W-1:0] tag_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_PAT_W-1:0] dpat_q;
	logic [TAG_PAT_W-1:0] tpat_q;
	logic [LW_CACHE_W-1:0] lw_cnt_q;
	logic [LW_CORE_W-1:0] lw_core_q;
	logic [1:0] clk_dly_q;
	logic burst_q, frame_q, pchk_q, stall_q;
	logic rise_en_q, fall_en_q, tfall_q, trise_q, fwd_en_q;
	logic [BEAT_W-1:0] beat_q;
	logic last_beat;

	assign req_ready = (state_q == ST_IDLE);
	assign accept = req_valid && req_ready;
	assign last_beat = (beat_q == BEAT_W'(FILL_BEATS - 1));

	// ==========================================================
	// Static configuration, sampled at each accepted request
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dpat_q <= DATA_PAT_RST;
			tpat_q <= TAG_PAT_RST;
			lw_core_q <= '0;
			clk_dly_q <= '0;
			burst_q <= 1'b0;
			frame_q <= 1'b0;
			pchk_q <= 1'b0;
			stall_q <= 1'b0;
			rise_en_q <= 1'b0;
			fall_en_q <= 1'b0;
			tfall_q <= 1'b0;
			trise_q <= 1'b0;
			fwd_en_q <= 1'b0;
		end else if (accept) begin
			dpat_q <= data_latency_pattern;
			tpat_q <= tag_latency_pattern;
			lw_core_q <= late_write_core_cycles;
			clk_dly_q <= cache_clock_phase_delay;
			burst_q <= burst_transfer_en;
			frame_q <= frame_on_a_phase;
			pchk_q <= probe_check_en;
			stall_q <= probe_stall_cfg;
			rise_en_q <= fwd_clock_rise_en;
			fall_en_q <= fwd_clock_fall_en;
			tfall_q <= tag_update_fall_en;
			trise_q <= tag_update_rise_en;
			fwd_en_q <= clock_forwarding_en;
		end else if (state_q == ST_RWAIT && data_rise) begin
			dpat_q <= dpat_q >> 1;
			tpat_q <= tpat_q >> 1;
		end
	end

	// ==========================================================
	// Core phase and cache clock generation
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			phase_a_q <= 1'b1;
			half_cnt_q <= '0;
			cclk_raw_q <= 1'b0;
		end else begin
			phase_a_q <= ~phase_a_q;
			if (half_cnt_q >= cache_clock_ratio) begin
				half_cnt_q <= '0;
				cclk_raw_q <= ~cclk_raw_q;
			end else begin
				half_cnt_q <= half_cnt_q + 1'b1;
			end
		end
	end
	assign raw_rise = (half_cnt_q >= cache_clock_ratio) && !cclk_raw_q;

	// ==========================================================
	// Phase delay line for data timing and forwarded clock
	always_comb begin
		case (clk_dly_q)
			2'h0: phase_dly = CLK_DELAY_ENC0;
			2'h1: phase_dly = CLK_DELAY_ENC1;
			2'h2: phase_dly = CLK_DELAY_ENC2;
			default: phase_dly = CLK_DELAY_ENC3;
		endcase
	end
	assign core_tap = TAP_W'(lw_core_q) * PHASES_PER_CORE;
	assign full_tap = core_tap + phase_dly;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cclk_line_q <= '0;
			data_clk_q <= 1'b0;
			fwd_src_q <= 1'b0;
		end else begin
			cclk_line_q <= {cclk_line_q[LINE_DEPTH-2:0], cclk_raw_q};
			data_clk_q <= cclk_line_q[core_tap];
			fwd_src_q <= cclk_line_q[full_tap];
		end
	end
	assign data_rise = cclk_line_q[core_tap] && !data_clk_q;
	assign fwd_rise = cclk_line_q[full_tap] && !fwd_src_q;
	assign fwd_fall = !cclk_line_q[full_tap] && fwd_src_q;

	// ==========================================================
	// Forwarded clock and tag outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fwd_clock <= 1'b0;
		end else if (!fwd_en_q) begin
			fwd_clock <= 1'b0;
		end else if (fwd_rise && rise_en_q) begin
			fwd_clock <= 1'b1;
		end else if (fwd_fall && fall_en_q) begin
			fwd_clock <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cache_tag_out <= '0;
		end else if ((fwd_rise && trise_q) || (fwd_fall && tfall_q)) begin
			cache_tag_out <= tag_q;
		end
	end

	// ==========================================================
	// Pin input synchronisers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			din_s1_q <= '0;
			din_s2_q <= '0;
			tin_s1_q <= '0;
			tin_s2_q <= '0;
			dpar_s1_q <= 1'b0;
			dpar_s2_q <= 1'b0;
			tpar_s1_q <= 1'b0;
			tpar_s2_q <= 1'b0;
		end else begin
			din_s1_q <= cache_data_in;
			din_s2_q <= din_s1_q;
			tin_s1_q <= cache_tag_in;
			tin_s2_q <= tin_s1_q;
			dpar_s1_q <= cache_data_par_in;
			dpar_s2_q <= dpar_s1_q;
			tpar_s1_q <= cache_tag_par_in;
			tpar_s2_q <= tpar_s1_q;
		end
	end

	// ==========================================================
	// System port commands
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sys_spec_read <= 1'b0;
			sys_stc_cmd <= 1'b0;
		end else begin
			sys_spec_read <= accept && !req_write && req_spec_read && speculative_read_en;
			sys_stc_cmd <= accept && req_stc && store_cond_export_en;
		end
	end

	// ==========================================================
	// Transaction sequencer
	// Framed start slips one phase when the cache clock rises on a B phase
	assign start_ok = (frame_q ? (phase_a_q && (raw_rise || (cclk_raw_q && !cclk_line_q[0])))
		: raw_rise)
		&& !(probe_q && stall_q && !data_clk_q);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			wr_q <= 1'b0;
			probe_q <= 1'b0;
			idx_q <= '0;
			tag_q <= '0;
			wdata_q <= '0;
			lw_cnt_q <= '0;
			beat_q <= '0;
			cache_index <= '0;
			cache_index_valid <= 1'b0;
			cache_data_out <= '0;
			cache_data_oe <= 1'b0;
			rsp_data <= '0;
			rsp_data_valid <= 1'b0;
			rsp_tag <= '0;
			rsp_tag_valid <= 1'b0;
			probe_error <= 1'b0;
		end else begin
			cache_index_valid <= 1'b0;
			rsp_data_valid <= 1'b0;
			rsp_tag_valid <= 1'b0;
			probe_error <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					cache_data_oe <= 1'b0;
					if (accept) begin
						wr_q <= req_write;
						probe_q <= req_probe;
						idx_q <= req_index;
						tag_q <= req_tag;
						wdata_q <= req_wdata;
						lw_cnt_q <= late_write_cache_clocks;
						beat_q <= '0;
						state_q <= ST_ALIGN;
					end
				end
				ST_ALIGN: begin
					if (start_ok) begin
						cache_index <= idx_q;
						cache_index_valid <= 1'b1;
						state_q <= wr_q ? ST_WDELAY : ST_RWAIT;
					end
				end
				ST_WDELAY: begin
					if (data_rise) begin
						if (lw_cnt_q == '0) begin
							cache_data_out <= wdata_q;
							cache_data_oe <= 1'b1;
							state_q <= ST_WDATA;
						end else begin
							lw_cnt_q <= lw_cnt_q - 1'b1;
						end
					end
				end
				ST_WDATA: begin
					if (data_rise) begin
						cache_data_oe <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_RWAIT: begin
					if (data_rise) begin
						if (tpat_q[0]) begin
							rsp_tag <= tin_s2_q;
							rsp_tag_valid <= 1'b1;
							probe_error <= probe_q && pchk_q && ((^tin_s2_q) != tpar_s2_q);
						end
						if (dpat_q[0]) begin
							rsp_data <= din_s2_q;
							rsp_data_valid <= 1'b1;
							if (probe_q && pchk_q && ((^din_s2_q) != dpar_s2_q)) begin
								probe_error <= 1'b1;
							end
							beat_q <= beat_q + 1'b1;
							if (!burst_q && !last_beat) begin
								cache_index <= idx_q + IDX_W'(beat_q + 1'b1);
								cache_index_valid <= 1'b1;
							end
						end
						if ((dpat_q[0] && last_beat) || dpat_q == '0) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule // cache_port_timing

// *** dv/cache_port_props.sv ***
// Concurrent checks on the cache port timing block
`timescale 1ns/1ps
module cache_port_props (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic speculative_read_en,
	input wire logic store_cond_export_en,
	input wire logic clock_forwarding_en,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic req_spec_read,
	input wire logic req_stc,
	input wire logic cache_index_valid,
	input wire logic cache_data_oe,
	input wire logic fwd_clock,
	input wire logic sys_spec_read,
	input wire logic sys_stc_cmd
);
	// ==========
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic acc;
	logic sp_acc;
	logic sc_acc;
	assign acc = req_valid && req_ready;
	assign sp_acc = acc && !req_write && req_spec_read && speculative_read_en;
	assign sc_acc = acc && req_stc && store_cond_export_en;
	chk_spec_issue: assert property (sp_acc |-> ##[1:2] sys_spec_read)
		else $error("speculative read not issued");
	chk_spec_cause: assert property (sys_spec_read |-> $past(sp_acc) || $past(sp_acc, 2))
		else $error("speculative read without cause");
	chk_stc_issue: assert property (sc_acc |-> ##[1:2] sys_stc_cmd)
		else $error("store conditional not exported");
	chk_stc_cause: assert property (sys_stc_cmd |-> $past(sc_acc) || $past(sc_acc, 2))
		else $error("store conditional without cause");
	chk_busy_accept: assert property (acc |=> !req_ready)
		else $error("ready high after accept");
	chk_index_within: assert property (acc |-> ##[1:30] cache_index_valid)
		else $error("index not presented in time");
	chk_fwd_off: assert property (acc && !clock_forwarding_en |-> ##2 !fwd_clock [*8])
		else $error("forwarded clock while disabled");
	chk_oe_busy: assert property (cache_data_oe |-> !req_ready && !$past(req_ready))
		else $error("write data outside a write");
endmodule // cache_port_props

// *** dv/cache_sram_model.sv ***
// Behavioural external cache SRAM array
`timescale 1ns/1ps
module cache_sram_model (
	input wire logic clock,
	input wire logic [19:0] cache_index,
	input wire logic cache_index_valid,
	input wire logic [15:0] cache_data_out,
	input wire logic cache_data_oe,
	input wire logic [11:0] cache_tag_out,
	input wire logic bad_parity,
	output logic [15:0] cache_data_in,
	output logic cache_data_par_in,
	output logic [11:0] cache_tag_in,
	output logic cache_tag_par_in
);
	// ==========
	// Array
	logic [15:0] data_mem [16];
	logic [11:0] tag_mem [16];
	logic [3:0] addr_q;
	logic [3:0] addr;
	assign addr = cache_index_valid ? cache_index[3:0] : addr_q;
	always_ff @(posedge clock) begin
		if (cache_index_valid) addr_q <= cache_index[3:0];
		if (cache_data_oe) begin
			data_mem[addr] <= cache_data_out;
			tag_mem[addr] <= cache_tag_out;
		end
	end
	assign cache_data_in = data_mem[addr];
	assign cache_tag_in = tag_mem[addr];
	// Even parity, flipped on command
	assign cache_data_par_in = ^cache_data_in ^ bad_parity;
	assign cache_tag_par_in = ^cache_tag_in ^ bad_parity;
endmodule // cache_sram_model

// *** dv/tb_offchip_cache_port_timing.sv ***
// Self-checking bench for the off-chip cache port timing block
`timescale 1ns/1ps
module tb_offchip_cache_port_timing;
	// ==========
	// Signals
	logic clock = 0, sys_rst = 1, bad_parity = 0;
	logic speculative_read_en = 0, probe_check_en = 0, store_cond_export_en = 0;
	logic probe_stall_cfg = 1, burst_transfer_en = 0, frame_on_a_phase = 0;
	logic fwd_clock_rise_en = 1, fwd_clock_fall_en = 1;
	logic tag_update_fall_en = 1, tag_update_rise_en = 1, clock_forwarding_en = 1;
	logic req_valid = 0, req_write = 0, req_probe = 0, req_spec_read = 0, req_stc = 0;
	logic [2:0] cache_clock_ratio = 3'h3, late_write_cache_clocks = 3'h0;
	logic [1:0] late_write_core_cycles = 2'h1, cache_clock_phase_delay = 2'h0;
	logic [31:0] data_latency_pattern = 32'h0000_0006;
	logic [23:0] tag_latency_pattern = 24'h00_0004;
	logic [19:0] req_index = 20'h0_0005, cache_index, ix;
	logic [11:0] req_tag = 12'h000, cache_tag_out, cache_tag_in, rsp_tag, rt;
	logic [15:0] req_wdata = 16'h0000, cache_data_out, cache_data_in, rsp_data, rd, od;
	logic req_ready, cache_index_valid, cache_data_oe, cache_data_par_in, cache_tag_par_in;
	logic fwd_clock, rsp_data_valid, rsp_tag_valid, probe_error, sys_spec_read, sys_stc_cmd;
	logic sp, sc, pe, fh, pf;
	int fails = 0, comparisons = 0, ti, to, nd, nt, tp, tf, ni, ne = 0;
	always #12.5 clock = ~clock;
	// Core edges since reset release, odd on A-phase edges
	always @(posedge clock) ne <= sys_rst ? 0 : ne + 1;
	cache_port_timing cache_port_timing_i (.clock, .sys_rst, .speculative_read_en,
		.probe_check_en, .store_cond_export_en, .probe_stall_cfg, .cache_clock_ratio,
		.data_latency_pattern, .tag_latency_pattern, .late_write_cache_clocks,
		.late_write_core_cycles, .burst_transfer_en, .frame_on_a_phase,
		.cache_clock_phase_delay, .fwd_clock_rise_en, .fwd_clock_fall_en, .tag_update_fall_en,
		.tag_update_rise_en, .clock_forwarding_en, .req_valid, .req_ready, .req_write,
		.req_probe, .req_spec_read, .req_stc, .req_index, .req_tag, .req_wdata, .cache_index,
		.cache_index_valid, .cache_data_out, .cache_data_oe, .cache_data_in, .cache_data_par_in,
		.cache_tag_out, .cache_tag_in, .cache_tag_par_in, .fwd_clock, .rsp_data,
		.rsp_data_valid, .rsp_tag, .rsp_tag_valid, .probe_error, .sys_spec_read, .sys_stc_cmd);
	cache_sram_model cache_sram_model_i (.clock, .cache_index, .cache_index_valid,
		.cache_data_out, .cache_data_oe, .cache_tag_out, .bad_parity, .cache_data_in,
		.cache_data_par_in, .cache_tag_in, .cache_tag_par_in);
	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic run(input logic w, p, s, c, input logic [11:0] tg, input logic [15:0] wd);
		int k;
		@(posedge clock);
		{req_write, req_probe, req_spec_read, req_stc} <= {w, p, s, c};
		{req_tag, req_wdata, req_valid} <= {tg, wd, 1'b1};
		{sp, sc, pe, fh, pf} = 5'h01;
		{ti, to, nd, nt} = {32'd0, 32'd0, 32'd0, 32'd0};
		{tp, tf, ni} = {32'd0, 32'd0, 32'd0};
		@(posedge clock);
		req_valid <= 1'b0;
		for (k = 0; k < 300; k++) begin
			#1;
			sp |= sys_spec_read;
			sc |= sys_stc_cmd;
			pe |= probe_error;
			fh |= fwd_clock && ti != 0;
			if (cache_index_valid && ti == 0) {ti, tp, ix} = {k, ne, cache_index};
			if (cache_index_valid) ni++;
			if (cache_data_oe && to == 0) {to, od} = {k, cache_data_out};
			if (fwd_clock && !pf && to != 0 && tf == 0) tf = k;
			pf = fwd_clock;
			if (rsp_data_valid) {nd, rd} = {nd + 1, nd == 0 ? rsp_data : rd};
			if (rsp_tag_valid) {nt, rt} = {nt + 1, nt == 0 ? rsp_tag : rt};
			if (req_ready) break;
			@(posedge clock);
		end
		if (k == 300) chk(0, 1);
		// Leave on an edge so the next settings change at a rising edge
		@(posedge clock);
	endtask
	// ==========
	// Scenarios
	task automatic t_system;
		for (int e = 0; e < 2; e++) begin
			{speculative_read_en, store_cond_export_en} <= {e[0], e[0]};
			run(0, 0, 1, 1, 12'h011, 16'h0000);
			chk(sp, e[0]);
			chk(sc, e[0]);
		end
		$display("system port test done");
	endtask
	task automatic t_write;
		int base;
		for (int n = 0; n < 8; n++) begin
			late_write_cache_clocks <= n[2:0];
			run(1, 0, 0, 0, 12'h0a0, 16'h1230 + n);
			if (n == 0) base = to - ti;
			chk(to - ti, base + n * 8);
			chk(od, 16'h1230 + n);
		end
		$display("late write test done");
	endtask
	task automatic t_core;
		int base;
		for (int c = 1; c < 4; c++) begin
			late_write_core_cycles <= c[1:0];
			run(1, 0, 0, 0, 12'h0a0, 16'h4560);
			if (c == 1) base = to - ti;
			chk(to - ti, base + 2 * (c - 1));
		end
		late_write_core_cycles <= 2'h1;
		$display("core late write test done");
	endtask
	task automatic t_read;
		run(1, 0, 0, 0, 12'h5a5, 16'hc3a5);
		for (int i = 0; i < 4; i++) begin
			burst_transfer_en <= i[1];
			data_latency_pattern <= i[0] ? 32'h0000_01f0 : 32'h0000_0006;
			tag_latency_pattern <= i[0] ? 24'h00_0030 : 24'h00_0002;
			run(0, 0, 0, 0, 12'h5a5, 16'h0000);
			chk(nd, i[0] ? 4 : 2);
			chk(ni == 1, i[1]);
			chk(ix, 20'h0_0005);
			chk(rd, 16'hc3a5);
			chk(nt, i[0] + 1);
			chk(rt, 12'h5a5);
		end
		$display("read test done");
	endtask
	task automatic t_probe;
		{cache_clock_ratio, probe_stall_cfg, bad_parity} <= {3'h1, 1'b0, 1'b1};
		for (int e = 0; e < 2; e++) begin
			probe_check_en <= e[0];
			run(0, 1, 0, 0, 12'h5a5, 16'h0000);
			chk(pe, e[0]);
		end
		{cache_clock_ratio, probe_stall_cfg, bad_parity} <= {3'h3, 1'b1, 1'b0};
		$display("probe test done");
	endtask
	task automatic t_fwd;
		for (int e = 0; e < 8; e++) begin
			{clock_forwarding_en, cache_clock_phase_delay, frame_on_a_phase} <= {e[2:0], e[0]};
			run(1, 0, 0, 0, 12'h5a5, 16'h0f00 + e);
			chk(fh, e[2]);
			chk(od, 16'h0f00 + e);
			if (e[0]) chk(tp % 2, 1);
			if (e[2]) chk(tf - to, e[1] ? e[0] + 1 : 0);
		end
		$display("forwarded clock test done");
	endtask
	task automatic t_tag;
		run(1, 0, 0, 0, 12'h0ff, 16'h0000);
		for (int e = 0; e < 3; e++) begin
			{tag_update_rise_en, tag_update_fall_en} <= 2'(e);
			run(1, 0, 0, 0, 12'h100 + e, 16'h0000);
			chk(cache_tag_out, e == 0 ? 32'h0ff : 32'h100 + e);
		end
		{tag_update_rise_en, tag_update_fall_en} <= 2'h3;
		$display("tag update test done");
	endtask
	// ==========
	// Sequence
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		t_system;
		t_write;
		t_core;
		t_read;
		t_probe;
		t_fwd;
		t_tag;
		report_and_stop;
	end
	initial begin
		#2_000_000;
		fails++;
		report_and_stop;
	end
endmodule // tb_offchip_cache_port_timing
bind cache_port_timing cache_port_props cache_port_props_i (.clock, .sys_rst,
	.speculative_read_en, .store_cond_export_en, .clock_forwarding_en, .req_valid, .req_ready,
	.req_write,
	.req_spec_read, .req_stc, .cache_index_valid, .cache_data_oe, .fwd_clock, .sys_spec_read,
	.sys_stc_cmd);
